// >>> include/tgc_pkg.sv
// shared constants for the gated 16-bit counter block
package tgc_pkg;
  // register offsets
  localparam logic [3:0] ADDR_CNT_LO  = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h1;
  localparam logic [3:0] ADDR_CTRL    = 4'h2;
  localparam logic [3:0] ADDR_CMP2    = 4'h3;
  localparam logic [3:0] ADDR_FLAG    = 4'h4;
  localparam logic [3:0] ADDR_IEN     = 4'h5;
  localparam logic [3:0] ADDR_CORE    = 4'h6;
  localparam logic [3:0] ADDR_CCP_LO  = 4'h7;
  localparam logic [3:0] ADDR_CCP_HI  = 4'h8;
  localparam logic [3:0] ADDR_CCP_MOD = 4'h9;
  localparam logic [3:0] ADDR_DIR     = 4'hA;
  localparam logic [3:0] ADDR_DATA    = 4'hB;
  // counter_control_reg fields
  localparam int CTRL_ON    = 0;
  localparam int CTRL_EXT   = 1;
  localparam int CTRL_SYNCB = 2;
  localparam int CTRL_OSC   = 3;
  localparam int CTRL_PS    = 4;
  localparam int CTRL_GE    = 6;
  localparam int CTRL_GINV  = 7;
  // comparator_ctrl_two fields
  localparam int CMP2_GSEL  = 0;
  localparam int CMP2_POL   = 2;
  localparam int CMP2_ACS   = 3;
  localparam int CMP2_CMP_OUTPUT  = 4;
  // core_int_control_reg fields
  localparam int CORE_PERIPH_INT_ENABLE  = 6;
  localparam int CORE_GIE   = 7;
  // capture/compare mode fields
  localparam int CCP_CAPT   = 0;
  localparam int CCP_COMP   = 1;
  localparam int CCP_SPEC   = 2;
  // pin bit positions
  localparam int PIN4       = 4;
  localparam int PIN5       = 5;
  // reset values and counts
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_DIR    = 8'h30;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [1:0]  ICYC_LAST  = 2'h3;
endpackage

// >>> sim/tgc_counter_top_test.sv
// self-checking bench for the gated 16-bit counter
`timescale 1ns/1ps
module tgc_counter_top_test
  import tgc_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rv;
  logic        ext_count_clock, osc_in, gate_pin, alt_gate_pin;
  logic        cmp_inv_below = 1'b0, sleep = 1'b0, sysclk = 1'b0, capture_event = 1'b0;
  logic        osc_run, pin4_dir, pin5_dir, cmp_output, overflow_irq, wake_req;
  logic        compare_event, special_event, hit;
  logic [15:0] cnt;
  int          err_count = 0, total_checks = 0;

  always #5 clk = ~clk;

  tgc_far_side tgc_far_side_inst (.ext_count_clock(ext_count_clock), .osc_in(osc_in),
    .gate_pin(gate_pin), .alt_gate_pin(alt_gate_pin));

  tgc_counter_top tgc_counter_top_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_count_clock(ext_count_clock), .osc_in(osc_in), .gate_pin(gate_pin),
    .alt_gate_pin(alt_gate_pin), .pin4_in(1'b1), .pin5_in(1'b1), .cmp_inv_below(cmp_inv_below),
    .sleep(sleep), .sysclk_intosc_or_lp(sysclk), .capture_event(capture_event),
    .osc_run(osc_run), .pin4_direction_bit(pin4_dir), .pin5_direction_bit(pin5_dir),
    .cmp_output(cmp_output), .overflow_irq(overflow_irq), .wake_req(wake_req),
    .compare_event(compare_event), .special_event(special_event));

  ////////////////////////////////////////////////////////////////////////////////
  // comparison, bus cycles and shared helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rd16();
    rd(ADDR_CNT_LO); cnt[7:0] = rv;
    rd(ADDR_CNT_HI); cnt[15:8] = rv;
  endtask
  // counter is stopped before its bytes are written, since a write racing an increment is unsafe
  task automatic load(input logic [15:0] v);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_LO, v[7:0]);
    wr(ADDR_CNT_HI, v[15:8]);
  endtask
  task automatic run(input logic [7:0] c, input int n);
    wr(ADDR_CTRL, c);
    repeat (n) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    rd16();
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(ADDR_DIR);    check("dir reset", rv, RST_DIR);
    rd(ADDR_CTRL);   check("ctrl reset", rv, RST_BYTE);
    rd(4'hC);        check("unmapped", rv, 8'h00);
    rd16();          check("count reset", cnt, CNT_ZERO);
    check("pin dirs", {pin5_dir, pin4_dir}, 2'b11);
  endtask
  task automatic t_osc();
    wr(ADDR_DIR, 8'h00);
    sysclk <= 1'b1;
    settle();        check("dir out", pin4_dir, 1'b0);
    // start-up wait is left to software before the counter is enabled
    wr(ADDR_CTRL, 8'h08);
    settle();        check("osc run", osc_run, 1'b1);
    check("dirs forced", {pin5_dir, pin4_dir}, 2'b11);
    rd(ADDR_DIR);    check("dir view", rv & 8'h30, 8'h30);
    rd(ADDR_DATA);   check("data view", rv & 8'h30, 8'h00);
    @(posedge clk) sysclk <= 1'b0;
    settle();        check("osc blocked", osc_run, 1'b0);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_DIR, RST_DIR);
  endtask
  task automatic t_prescale();
    for (int p = 0; p < 4; p++)
    begin
      load(CNT_ZERO);
      run(8'(p << CTRL_PS) | 8'h01, 320);
      check("ps count", 16'(cnt >= 16'(80 >> p) - 1 && cnt <= 16'(80 >> p) + 2), 16'h1);
      repeat (40) @(posedge clk);
      rd(ADDR_CNT_HI); check("held", rv, cnt[15:8]);
      rd(ADDR_CNT_LO); check("off holds", rv, cnt[7:0]);
    end
  endtask
  task automatic t_overflow();
    load(16'hFFFE);
    wr(ADDR_IEN, 8'h01); wr(ADDR_CORE, 8'hC0); wr(ADDR_FLAG, 8'h00);
    run(8'h01, 40);
    check("wrapped", 16'(cnt < 16'h0010), 16'h1);
    rd(ADDR_FLAG);   check("ovf flag", rv[0], 1'b1);
    settle();        check("irq on", overflow_irq, 1'b1);
    wr(ADDR_CORE, 8'h40);
    settle();        check("irq no global", overflow_irq, 1'b0);
    wr(ADDR_CORE, 8'hC0); wr(ADDR_FLAG, 8'h00);
    settle();        check("irq cleared", overflow_irq, 1'b0);
    wr(ADDR_CORE, 8'h00); wr(ADDR_IEN, 8'h00);
  endtask
  task automatic t_gate();
    tgc_far_side_inst.set_gate(1'b0, 1'b1);
    load(CNT_ZERO); run(8'h41, 100);  check("gate low", cnt, CNT_ZERO);
    run(8'h01, 100); check("no gate", 16'(cnt > 0), 16'h1);
    load(CNT_ZERO); run(8'hC1, 100);  check("gate inv", 16'(cnt > 0), 16'h1);
    wr(ADDR_CMP2, 8'h01);
    load(CNT_ZERO); run(8'h41, 100);  check("alt pin", 16'(cnt > 0), 16'h1);
    @(posedge clk) cmp_inv_below <= 1'b1;
    wr(ADDR_CMP2, 8'h02);
    settle();        check("cmp_output", cmp_output, 1'b1);
    load(CNT_ZERO); run(8'h41, 100);  check("cmp gate", 16'(cnt > 0), 16'h1);
    wr(ADDR_CMP2, 8'h06);
    settle();        check("cmp_output pol", cmp_output, 1'b0);
    load(CNT_ZERO); run(8'h41, 100);  check("cmp gate pol", cnt, CNT_ZERO);
    wr(ADDR_CMP2, 8'h00);
  endtask
  task automatic t_external();
    load(CNT_ZERO);
    wr(ADDR_CTRL, 8'h03);
    tgc_far_side_inst.pulses(5, 43);
    run(8'h03, 10);  check("ext sync", cnt, 16'h0005);
    load(CNT_ZERO);
    wr(ADDR_CTRL, 8'h13);
    tgc_far_side_inst.pulses(8, 43);
    run(8'h13, 10);  check("ext ps2", cnt, 16'h0004);
    load(CNT_ZERO);
    sleep <= 1'b1;
    run(8'h01, 100); check("sleep int", cnt, CNT_ZERO);
    load(16'hFFFE);
    wr(ADDR_IEN, 8'h01); wr(ADDR_CORE, 8'h40); wr(ADDR_FLAG, 8'h00);
    wr(ADDR_CTRL, 8'h07);
    tgc_far_side_inst.pulses(4, 43);
    settle();        check("wake", wake_req, 1'b1);
    check("no irq", overflow_irq, 1'b0);
    @(posedge clk) sleep <= 1'b0;
    wr(ADDR_CTRL, 8'h00); wr(ADDR_FLAG, 8'h00); wr(ADDR_IEN, 8'h00); wr(ADDR_CORE, 8'h00);
  endtask
  task automatic t_capture();
    load(16'h1234);
    wr(ADDR_CCP_MOD, 8'h01);
    @(posedge clk) capture_event <= 1'b1;
    @(posedge clk) capture_event <= 1'b0;
    rd(ADDR_CCP_LO); check("cap lo", rv, 8'h34);
    rd(ADDR_CCP_HI); check("cap hi", rv, 8'h12);
  endtask
  task automatic comp(input logic [7:0] mode, input logic [7:0] cmp2, input logic exp, input logic spec);
    load(CNT_ZERO);
    wr(ADDR_CCP_LO, 8'h10); wr(ADDR_CCP_HI, 8'h00);
    wr(ADDR_CCP_MOD, mode); wr(ADDR_CMP2, cmp2);
    wr(ADDR_CTRL, 8'h01);
    hit = 1'b0;
    repeat (200)
    begin
      @(posedge clk);
      #1 if ((spec ? special_event : compare_event) === 1'b1) hit = 1'b1;
    end
    wr(ADDR_CTRL, 8'h00); wr(ADDR_CMP2, 8'h00);
    check("compare", hit, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // whole sequence needs roughly 3.4k cycles
  initial
  begin
    #(60000 * 10);
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset(); t_osc(); t_prescale(); t_overflow();
    t_gate(); t_external(); t_capture();
    comp(8'h02, 8'h00, 1'b1, 1'b0);
    comp(8'h06, 8'h00, 1'b1, 1'b1);
    comp(8'h02, 8'h08, 1'b0, 1'b0);
    complete_run();
  end
endmodule // tgc_counter_top_test

// >>> sim/tgc_far_side.sv
// far side model: external count clock, crystal and gate pins
`timescale 1ns/1ps
module tgc_far_side
(
  // pins toward the block
  output logic ext_count_clock,
  output logic osc_in,
  output logic gate_pin,
  output logic alt_gate_pin
);
  // count clock idles low between bursts, so the first edge of each burst is a rise
  initial
  begin
    ext_count_clock = 1'b0;
    osc_in          = 1'b0;
    gate_pin        = 1'b0;
    alt_gate_pin    = 1'b0;
  end
  // crystal runs free and much slower than the system clock
  always #150 osc_in = ~osc_in;
  // burst of n rising edges, unrelated in phase to the system clock
  task automatic pulses(input int n, input int half_ns);
    repeat (n)
    begin
      #(half_ns) ext_count_clock = 1'b1;
      #(half_ns) ext_count_clock = 1'b0;
    end
  endtask
  // gate levels held until changed
  task automatic set_gate(input logic g, input logic a);
    gate_pin     <= g;
    alt_gate_pin <= a;
  endtask
endmodule // tgc_far_side

// >>> src/tgc_counter_top.sv
// gated 16-bit counter with prescaler, crystal source, gate and time-base outputs
//
// Functional notes
// - crystal oscillator enabled by control bit, keeps running in sleep.
// - crystal usable only with internal or low-power system clock.
// - oscillator enabled forces both pin directions to input, data reads zero.
// - sync bypass counts external clock unsynchronised, runs in sleep, overflow wakes.
// - mode switch may skip or add one increment.
// - async or alternate internal clock: no capture/compare time base.
// - count bytes always read back valid values.
// - gate source from pin, alternate pin or comparator output.
// - gate acts only while gate enable is set.
// - gate invert bit flips selected gate signal.
// - count wraps FFFF to 0000 and sets overflow flag.
// - interrupt needs overflow, peripheral and global enables; flag clear ends it.
// - counting in sleep only in asynchronous external mode.
// - overflow in sleep with on and enables set wakes core.
// - capture copies count on configured event.
// - compare match triggers event, optionally special trigger.
// - comparator output high when inverting below non-inverting, polarity inverts.
// - comparator output registered once per instruction cycle.
// - prescaler 1/2/4/8, cleared on count byte write.
// - external clock counts rising edges, synchronised or not.
// - internal clock counts instruction cycles through prescaler.
`timescale 1ns/1ps
module tgc_counter_top
  import tgc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       ext_count_clock,
  input  wire logic       osc_in,
  input  wire logic       gate_pin,
  input  wire logic       alt_gate_pin,
  input  wire logic       pin4_in,
  input  wire logic       pin5_in,
  // comparator: high when inverting input is below non-inverting input
  input  wire logic       cmp_inv_below,
  // system state
  input  wire logic       sleep,
  input  wire logic       sysclk_intosc_or_lp,
  input  wire logic       capture_event,
  // outputs
  output logic            osc_run,
  output logic            pin4_direction_bit,
  output logic            pin5_direction_bit,
  output logic            cmp_output,
  output logic            overflow_irq,
  output logic            wake_req,
  output logic            compare_event,
  output logic            special_event
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] count_reg, capture_reg;
  logic [7:0]  ctrl_reg, cmp2_reg, ccp_mode_reg, dir_reg, core_reg, rdata_reg;
  logic        flag_reg, ien_reg, cmp_output_reg, match_reg;
  logic [1:0]  icyc_reg;
  logic        osc_run_reg, dir4_reg, dir5_reg, irq_reg, wake_reg, cmpev_reg, spec_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and control fields
  wire wr_lo   = reg_wr && reg_addr == ADDR_CNT_LO;
  wire wr_hi   = reg_wr && reg_addr == ADDR_CNT_HI;
  wire cnt_wr  = wr_lo || wr_hi;
  wire wr_flag = reg_wr && reg_addr == ADDR_FLAG;

  wire       on_b    = ctrl_reg[CTRL_ON];
  wire       ext_b   = ctrl_reg[CTRL_EXT];
  wire       async_b = ctrl_reg[CTRL_SYNCB];
  wire       osc_b   = ctrl_reg[CTRL_OSC];
  wire [1:0] ps_sel  = ctrl_reg[CTRL_PS+1:CTRL_PS];
  wire       ge_b    = ctrl_reg[CTRL_GE];
  wire       ginv_b  = ctrl_reg[CTRL_GINV];
  wire [1:0] gsel    = cmp2_reg[CMP2_GSEL+1:CMP2_GSEL];
  wire       pol_b   = cmp2_reg[CMP2_POL];
  wire       acs_b   = cmp2_reg[CMP2_ACS];
  wire       periph_int_enable_b  = core_reg[CORE_PERIPH_INT_ENABLE];
  wire       gie_b   = core_reg[CORE_GIE];

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable from a divide-by-four; halted in sleep
  wire icyc_tick = !sleep && icyc_reg == ICYC_LAST;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      icyc_reg <= 2'h0;
    else if (!sleep)
      icyc_reg <= icyc_reg + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source: crystal shares the low-power oscillator, so it only runs
  // when the system clock is the internal or the low-power oscillator
  wire osc_ok   = osc_b && sysclk_intosc_or_lp;
  wire ext_src  = osc_ok ? osc_in : ext_count_clock;
  wire ext_rise;
  wire async_md = ext_b && async_b;

  tgc_edge_det tgc_edge_det_inst (
    .clk     (clk),
    .reset_n (reset_n),
    .sig     (ext_src),
    .bypass  (async_b),
    .rise    (ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // comparator output sampled once per instruction cycle
  wire cmp_now = cmp_inv_below ^ pol_b;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cmp_output_reg <= 1'b0;
    else if (icyc_tick)
      cmp_output_reg <= cmp_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate select, invert and enable
  wire gate_raw = gsel[1] ? cmp_output_reg : (gsel[0] ? alt_gate_pin : gate_pin);
  wire gate_act = gate_raw ^ ginv_b;
  wire gate_ok  = !ge_b || gate_act;

  // only the asynchronous external path may count while asleep
  wire sleep_ok = !sleep || async_md;
  wire run_now  = on_b && gate_ok && sleep_ok;
  wire src_tick = ext_b ? ext_rise : icyc_tick;
  wire ps_pulse;

  tgc_prescaler tgc_prescaler_inst (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (src_tick && run_now),
    .clr     (cnt_wr),
    .sel     (ps_sel),
    .pulse   (ps_pulse)
  );

  // the pending pulse is gated again so stopping takes effect at once
  wire inc  = ps_pulse && run_now && !cnt_wr;
  wire wrap = inc && count_reg == CNT_MAX;

  ////////////////////////////////////////////////////////////////////////////
  // count register; a byte write wins over an increment in the same cycle,
  // which gives a defined result where software ignores the stop advice
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      count_reg <= CNT_ZERO;
    else if (wr_lo)
      count_reg[7:0] <= reg_wdata;
    else if (wr_hi)
      count_reg[15:8] <= reg_wdata;
    else if (inc)
      count_reg <= count_reg + 16'h0001;
  end

  // overflow flag: set beats a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      flag_reg <= 1'b0;
    else if (wrap)
      flag_reg <= 1'b1;
    else if (wr_flag)
      flag_reg <= reg_wdata[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_reg     <= RST_BYTE;
      cmp2_reg     <= RST_BYTE;
      ccp_mode_reg <= RST_BYTE;
      core_reg     <= RST_BYTE;
      dir_reg      <= RST_DIR;
      ien_reg      <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CTRL:    ctrl_reg     <= reg_wdata;
        ADDR_CMP2:    cmp2_reg     <= {4'h0, reg_wdata[3:0]};
        ADDR_CCP_MOD: ccp_mode_reg <= {5'h00, reg_wdata[2:0]};
        ADDR_CORE:    core_reg     <= {reg_wdata[7:6], 6'h00};
        ADDR_DIR:     dir_reg      <= reg_wdata;
        ADDR_IEN:     ien_reg      <= reg_wdata[0];
        default:      ien_reg      <= ien_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture / compare time base; not valid from an unsynchronised source
  wire tb_ok    = !async_md && !(!ext_b && acs_b);
  wire capt_go  = ccp_mode_reg[CCP_CAPT] && capture_event && tb_ok;
  wire match    = ccp_mode_reg[CCP_COMP] && tb_ok && count_reg == capture_reg;
  wire wr_ccplo = reg_wr && reg_addr == ADDR_CCP_LO;
  wire wr_ccphi = reg_wr && reg_addr == ADDR_CCP_HI;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      capture_reg <= CNT_ZERO;
      match_reg   <= 1'b0;
    end
    else
    begin
      match_reg <= match;
      if (capt_go)
        capture_reg <= count_reg;
      else if (wr_ccplo)
        capture_reg[7:0] <= reg_wdata;
      else if (wr_ccphi)
        capture_reg[15:8] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire irq_now  = flag_reg && ien_reg && periph_int_enable_b && gie_b;
  wire wake_now = sleep && flag_reg && ien_reg && periph_int_enable_b && on_b;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      {osc_run_reg, dir4_reg, dir5_reg, irq_reg} <= 4'h0;
      {wake_reg, cmpev_reg, spec_reg} <= 3'h0;
    end
    else
    begin
      osc_run_reg <= osc_ok;
      dir4_reg    <= dir_reg[PIN4] || osc_b;
      dir5_reg    <= dir_reg[PIN5] || osc_b;
      irq_reg     <= irq_now;
      wake_reg    <= wake_now;
      cmpev_reg   <= match && !match_reg;
      spec_reg    <= match && !match_reg && ccp_mode_reg[CCP_SPEC];
    end
  end

  assign osc_run            = osc_run_reg;
  assign pin4_direction_bit = dir4_reg;
  assign pin5_direction_bit = dir5_reg;
  assign cmp_output         = cmp_output_reg;
  assign overflow_irq       = irq_reg;
  assign wake_req           = wake_reg;
  assign compare_event      = cmpev_reg;
  assign special_event      = spec_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; pins under the crystal read as zero and as inputs
  wire [7:0] dir_view  = dir_reg | (osc_b ? RST_DIR : 8'h00);
  wire [7:0] data_view = {2'h0, pin5_in & !osc_b, pin4_in & !osc_b, 4'h0};
  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      ADDR_CNT_LO:  rd_mux = count_reg[7:0];
      ADDR_CNT_HI:  rd_mux = count_reg[15:8];
      ADDR_CTRL:    rd_mux = ctrl_reg;
      ADDR_CMP2:    rd_mux = {3'h0, cmp_output_reg, cmp2_reg[3:0]};
      ADDR_FLAG:    rd_mux = {7'h00, flag_reg};
      ADDR_IEN:     rd_mux = {7'h00, ien_reg};
      ADDR_CORE:    rd_mux = core_reg;
      ADDR_CCP_LO:  rd_mux = capture_reg[7:0];
      ADDR_CCP_HI:  rd_mux = capture_reg[15:8];
      ADDR_CCP_MOD: rd_mux = ccp_mode_reg;
      ADDR_DIR:     rd_mux = dir_view;
      ADDR_DATA:    rd_mux = data_view;
      default:      rd_mux = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_WRAP: assert property (wrap |=> count_reg == CNT_ZERO && flag_reg)
    else $error("wrap did not clear count or set flag");
  // any register write may drop an enable or the flag one cycle later, so only quiet cycles count
  AST_IRQ: assert property (irq_now && !reg_wr |=> overflow_irq ##1 overflow_irq)
    else $error("interrupt request missing");
  AST_IRQ_IEN: assert property (!ien_reg |=> !overflow_irq)
    else $error("interrupt without overflow enable");
  // one step per increment away from the wrap point
  AST_STEP: assert property (inc && count_reg != CNT_MAX |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not advance by one");
  // a wrap must not be lost to a software clear in the same cycle
  AST_SET_WINS: assert property (wrap && wr_flag |=> flag_reg)
    else $error("overflow flag lost to clear");
  AST_WAKE_AWAKE: assert property (!sleep |=> !wake_req)
    else $error("wake request while awake");
  AST_OSC_BLOCK: assert property (!sysclk_intosc_or_lp |=> !osc_run)
    else $error("crystal running with incompatible system clock");
  // compare event is a single-cycle pulse even while the match persists
  AST_COMP_PULSE: assert property (compare_event |=> !compare_event)
    else $error("compare event longer than one cycle");
  AST_IRQ_OFF: assert property (!gie_b |=> !overflow_irq)
    else $error("interrupt without global enable");
  AST_OFF_HOLD: assert property (!on_b && !cnt_wr |=> $stable(count_reg))
    else $error("count moved while off");
  AST_GATE_HOLD: assert property (ge_b && !gate_act && !cnt_wr |=> $stable(count_reg))
    else $error("count moved while gated off");
  AST_SLEEP_HOLD: assert property (sleep && !async_md && !cnt_wr |=> $stable(count_reg))
    else $error("count moved in sleep without async mode");
  AST_CAPTURE: assert property (capt_go |=> capture_reg == $past(count_reg))
    else $error("capture value wrong");
  AST_NO_TB: assert property (!tb_ok |=> !compare_event)
    else $error("compare event without valid time base");
  AST_PIN_DIR: assert property (osc_b |=> pin4_direction_bit && pin5_direction_bit)
    else $error("pin directions not forced by oscillator");
  AST_CMP_LATCH: assert property (icyc_tick |=> cmp_output == $past(cmp_now))
    else $error("comparator output not latched");
endmodule // tgc_counter_top

// >>> src/tgc_edge_det.sv
// rising-edge detector with optional two-stage synchroniser
`timescale 1ns/1ps
module tgc_edge_det
  import tgc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // source and mode
  input  wire logic sig,
  input  wire logic bypass,
  // result
  output logic      rise
);
  logic s1_reg, s2_reg, s3_reg, a1_reg, a2_reg;
  wire  rise_sync  = s2_reg & ~s3_reg;
  wire  rise_async = a1_reg & ~a2_reg;

  // s1 is only ever read by s2
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      {s1_reg, s2_reg, s3_reg, a1_reg, a2_reg} <= 5'h00;
    end
    else
    begin
      s1_reg <= sig;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      a1_reg <= sig;
      a2_reg <= a1_reg;
    end
  end

  // bypass path is shorter, so a mode change may skip or add one edge
  assign rise = bypass ? rise_async : rise_sync;
endmodule // tgc_edge_det

// >>> src/tgc_prescaler.sv
// 1/2/4/8 prescaler that emits one pulse per ratio of input ticks
`timescale 1ns/1ps
module tgc_prescaler
  import tgc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       tick,
  input  wire logic       clr,
  input  wire logic [1:0] sel,
  // result
  output logic            pulse
);
  logic [2:0] cnt_reg;
  logic       pulse_reg;
  wire  [2:0] last = 3'((4'h1 << sel) - 4'h1);
  wire        hit  = tick && (cnt_reg == last);

  // count wraps at the selected ratio; a clear drops partial counts
  always_ff @(posedge clk)
  begin
    if (!reset_n || clr)
    begin
      cnt_reg   <= 3'h0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= hit;
      if (tick)
        cnt_reg <= hit ? 3'h0 : cnt_reg + 3'h1;
    end
  end
  assign pulse = pulse_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_PRESC_CLR: assert property (clr |=> cnt_reg == 3'h0 && !pulse)
    else $error("prescaler not cleared");
endmodule // tgc_prescaler
